// >>> tkei_map.vh
// Register map, field layout, reset values and timing constants of the key event logic
`ifndef TKEI_MAP_VH
`define TKEI_MAP_VH

`define TKEI_NKEYS        16
// Register word indices; byte address is four times the index
`define TKEI_IDX_KEY_LO   6'h02
`define TKEI_IDX_KEY_HI   6'h03
`define TKEI_IDX_CTRL     6'h04
`define TKEI_IDX_HOLD     6'h05
`define TKEI_IDX_ACLR     6'h06
`define TKEI_IDX_SSC      6'h07
`define TKEI_IDX_RPT      6'h08
`define TKEI_IDX_IST      6'h09
`define TKEI_IDX_IMSK     6'h0A

// Control register fields
`define TKEI_CTRL_W       7
`define TKEI_CTRL_RST     7'h40
`define TKEI_CTRL_HOLD_EN 0
`define TKEI_CTRL_ACLR_EN 1
`define TKEI_CTRL_LIM_EN  2
`define TKEI_CTRL_LIM_LO  3
`define TKEI_CTRL_LIM_HI  4
`define TKEI_CTRL_MODE    5
`define TKEI_CTRL_GIE     6

// Other reset values
`define TKEI_HOLD_RST     8'h05
`define TKEI_ACLR_RST     8'hC8
`define TKEI_RATE_RST     4'h0
`define TKEI_AMP_RST      6'h04
`define TKEI_FIRST_RST    16'h03E8
`define TKEI_RPT_RST      16'h0000

// SSC register fields
`define TKEI_SSC_RATE_HI  3
`define TKEI_SSC_AMP_LO   8
`define TKEI_SSC_AMP_HI   13

// Interrupt status bits
`define TKEI_IST_W        3
`define TKEI_IST_KEY      0
`define TKEI_IST_RECAL    1
`define TKEI_IST_ACLR     2

// Timing: clock rate, timer tick and seconds per tick chain
`define TKEI_CLK_KHZ      250000
`define TKEI_TICK_MS      1
`define TKEI_MS_PER_S     1000
`define TKEI_TICK_W       18

`endif

// >>> tkei_tick.v
// Pulse divider: one tick for every DIV input steps
`timescale 1ns/1ns
`default_nettype none
module tkei_tick #(
  parameter integer W   = 18,
  parameter integer DIV = 1000
) (
  input  wire clk,
  input  wire rst,
  input  wire step,
  output wire tick
);
  localparam [31:0]  LAST32 = DIV - 1;
  localparam [W-1:0] LAST   = LAST32[W-1:0];
  localparam [W-1:0] ONE    = 1;
  reg [W-1:0] cnt_r;

  assign tick = step & (cnt_r == LAST);

  always @(posedge clk)
  begin
    if (rst)
      cnt_r <= {W{1'b0}};
    else if (tick)
      cnt_r <= {W{1'b0}};
    else if (step)
      cnt_r <= cnt_r + ONE;
  end
endmodule // tkei_tick
`default_nettype wire

// >>> tkei_top.v
// Touch key event, interrupt, limiter, hold supervision and spread spectrum logic
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "tkei_map.vh"

// Function
// - A control bit enables or disables supervision of key press duration.
// - Key held for the limit in seconds gets a forced recalibration.
// - Without auto-clear, the interrupt pin stays low until both status registers are read.
// - With auto-clear, reads or expiry of the programmed millisecond time release the pin.
// - Sweep rate zero turns spread spectrum off; any other value turns it on.
// - The amplitude setting bounds the scan frequency deviation while sweeping.
// - Limiter off: every pressed key is reported, except a recalibrated key until it is let go.
// - Limiter on: at most one, two or three keys reported together.
// - Mode zero: one interrupt on press and one on release.
// - Mode one: repeated interrupts while held, one on release.
// - Second interrupt after first-repeat interval, later ones every repeat interval.
// - Global interrupt enable gates every key interrupt.
module tkei_top #(
  parameter integer MS_CYCLES = `TKEI_TICK_MS * `TKEI_CLK_KHZ
) (
  input  wire        REF_CLK,
  input  wire        RST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  input  wire [15:0] KEY_PRESS,
  output wire [15:0] KEY_STATE,
  output wire [15:0] RECAL_REQ,
  output wire        IRQ_N,
  output wire        IRQ,
  output wire        SSC_ACTIVE,
  output wire [7:0]  SSC_OFFSET
);
  localparam [15:0] ONE16 = 16'h0001;
  localparam [7:0]  ONE8  = 8'h01;
  localparam [7:0]  SAT8  = 8'hFF;
  localparam [3:0]  ONE4  = 4'h1;
  localparam [1:0]  LIM1  = 2'h1;

  function [4:0] tkei_popcnt;
    input [15:0] v;
    integer k;
    begin
      tkei_popcnt = 5'h00;
      for (k = 0; k < `TKEI_NKEYS; k = k + 1)
        tkei_popcnt = tkei_popcnt + {4'h0, v[k]};
    end
  endfunction

  // Configuration, status and read data registers
  reg  [`TKEI_CTRL_W-1:0] ctrl_r;
  reg  [7:0]              hold_s_r;
  reg  [7:0]              aclr_ms_r;
  reg  [3:0]              ssc_rate_r;
  reg  [5:0]              ssc_amp_r;
  reg  [15:0]             first_ms_r;
  reg  [15:0]             rpt_ms_r;
  reg  [`TKEI_IST_W-1:0]  ist_r;
  reg  [`TKEI_IST_W-1:0]  imsk_r;
  reg  [31:0]             prdata_r;

  // Key, interrupt and sweep state
  reg  [15:0]             rep_r;
  reg  [15:0]             rep_nxt;
  reg  [15:0]             supp_r;
  reg  [15:0]             recal_r;
  reg  [7:0]              held_s_r [0:15];
  reg  [15:0]             rpt_cnt_r;
  reg                     rpt_first_r;
  reg                     pin_act_r;
  reg                     rd_lo_r;
  reg                     rd_hi_r;
  reg  [7:0]              aclr_cnt_r;
  reg  [3:0]              ssc_div_r;
  reg  [7:0]              ssc_pos_r;
  reg                     ssc_up_r;

  reg                     hit;
  reg  [31:0]             rd_val;
  reg  [15:0]             keep;
  reg  [4:0]              nsel;
  reg  [15:0]             recal_nxt;
  integer                 i;
  integer                 j;
  integer                 m;

  wire ms_tick;
  wire s_tick;

  tkei_tick #(.W(`TKEI_TICK_W), .DIV(MS_CYCLES)) u_ms_tick (
    .clk  (REF_CLK),
    .rst  (RST),
    .step (1'b1),
    .tick (ms_tick)
  );

  tkei_tick #(.W(`TKEI_TICK_W), .DIV(`TKEI_MS_PER_S)) u_s_tick (
    .clk  (REF_CLK),
    .rst  (RST),
    .step (ms_tick),
    .tick (s_tick)
  );

  // APB decode
  wire       apb_setup = PSEL & ~PENABLE;
  wire       apb_acc   = PSEL & PENABLE;
  wire [5:0] idx       = PADDR[7:2];
  wire       aligned   = (PADDR[1:0] == 2'b00);
  wire       wr_en     = apb_acc & PWRITE & hit;
  wire       rd_lo     = apb_acc & ~PWRITE & hit & (idx == `TKEI_IDX_KEY_LO);
  wire       rd_hi     = apb_acc & ~PWRITE & hit & (idx == `TKEI_IDX_KEY_HI);

  always @*
  begin
    hit    = aligned;
    rd_val = 32'h00000000;
    if (idx == `TKEI_IDX_KEY_LO)
      rd_val = {24'h000000, rep_r[7:0]};
    else if (idx == `TKEI_IDX_KEY_HI)
      rd_val = {24'h000000, rep_r[15:8]};
    else if (idx == `TKEI_IDX_CTRL)
      rd_val = {25'h0000000, ctrl_r};
    else if (idx == `TKEI_IDX_HOLD)
      rd_val = {24'h000000, hold_s_r};
    else if (idx == `TKEI_IDX_ACLR)
      rd_val = {24'h000000, aclr_ms_r};
    else if (idx == `TKEI_IDX_SSC)
      rd_val = {18'h00000, ssc_amp_r, 4'h0, ssc_rate_r};
    else if (idx == `TKEI_IDX_RPT)
      rd_val = {rpt_ms_r, first_ms_r};
    else if (idx == `TKEI_IDX_IST)
      rd_val = {29'h00000000, ist_r};
    else if (idx == `TKEI_IDX_IMSK)
      rd_val = {29'h00000000, imsk_r};
    else
      hit = 1'b0;
  end

  assign PREADY  = 1'b1;
  assign PSLVERR = apb_acc & ~hit;
  assign PRDATA  = prdata_r;

  wire       hold_en = ctrl_r[`TKEI_CTRL_HOLD_EN];
  wire       aclr_en = ctrl_r[`TKEI_CTRL_ACLR_EN];
  wire       lim_en  = ctrl_r[`TKEI_CTRL_LIM_EN];
  wire [1:0] lim_fld = ctrl_r[`TKEI_CTRL_LIM_HI:`TKEI_CTRL_LIM_LO];
  wire       mode1   = ctrl_r[`TKEI_CTRL_MODE];
  wire       gie     = ctrl_r[`TKEI_CTRL_GIE];
  wire [1:0] lim_val = (lim_fld == 2'b00) ? LIM1 : lim_fld;

  // Candidate keys: a recalibrated key stays hidden until it is let go
  wire [15:0] cand = KEY_PRESS & ~supp_r;

  // Limiter keeps already reported keys and admits new ones lowest index first
  always @*
  begin
    keep = rep_r & cand;
    nsel = tkei_popcnt(keep);
    rep_nxt = keep;
    if (!lim_en)
      rep_nxt = cand;
    else
    begin
      for (i = 0; i < `TKEI_NKEYS; i = i + 1)
      begin
        if (cand[i] && !keep[i] && (nsel < {3'b000, lim_val}))
        begin
          rep_nxt[i] = 1'b1;
          nsel = nsel + 5'h01;
        end
      end
    end
  end

  // Hold supervision: a key reported for the limit in seconds is recalibrated
  always @*
  begin
    recal_nxt = 16'h0000;
    // A key already hidden is skipped so the request lasts one cycle
    for (j = 0; j < `TKEI_NKEYS; j = j + 1)
      recal_nxt[j] = hold_en & rep_r[j] & ~supp_r[j] & (held_s_r[j] >= hold_s_r);
  end

  always @(posedge REF_CLK)
  begin
    if (RST)
    begin
      supp_r  <= 16'h0000;
      recal_r <= 16'h0000;
      for (m = 0; m < `TKEI_NKEYS; m = m + 1)
        held_s_r[m] <= 8'h00;
    end
    else
    begin
      recal_r <= recal_nxt;
      supp_r  <= (supp_r & KEY_PRESS) | recal_nxt;
      for (m = 0; m < `TKEI_NKEYS; m = m + 1)
      begin
        if (!rep_r[m])
          held_s_r[m] <= 8'h00;
        else if (s_tick && (held_s_r[m] != SAT8))
          held_s_r[m] <= held_s_r[m] + ONE8;
      end
    end
  end

  // Key change and repeat events
  wire key_chg = (rep_nxt != rep_r);
  wire any_hld = |rep_r;
  wire [15:0] rpt_inc = rpt_cnt_r + ONE16;
  wire rpt_ev = mode1 & any_hld & ~key_chg & ms_tick &
                ((~rpt_first_r & (rpt_inc >= first_ms_r)) |
                 (rpt_first_r & (rpt_ms_r != 16'h0000) & (rpt_inc >= rpt_ms_r)));
  wire key_ev = gie & (key_chg | rpt_ev);

  always @(posedge REF_CLK)
  begin
    if (RST)
    begin
      rep_r       <= 16'h0000;
      rpt_cnt_r   <= 16'h0000;
      rpt_first_r <= 1'b0;
    end
    else
    begin
      rep_r <= rep_nxt;
      if (key_chg || !any_hld || !mode1)
      begin
        rpt_cnt_r   <= 16'h0000;
        rpt_first_r <= 1'b0;
      end
      else if (rpt_ev)
      begin
        rpt_cnt_r   <= 16'h0000;
        rpt_first_r <= 1'b1;
      end
      else if (ms_tick && (rpt_cnt_r != 16'hFFFF))
        rpt_cnt_r <= rpt_inc;
    end
  end

  assign KEY_STATE = rep_r;
  assign RECAL_REQ = recal_r;

  // Interrupt pin: asserted by events, released by status reads or auto-clear
  wire both_rd  = (rd_lo_r | rd_lo) & (rd_hi_r | rd_hi);
  wire aclr_exp = aclr_en & ms_tick & ((aclr_cnt_r + ONE8) >= aclr_ms_r);

  always @(posedge REF_CLK)
  begin
    if (RST)
    begin
      pin_act_r  <= 1'b0;
      rd_lo_r    <= 1'b0;
      rd_hi_r    <= 1'b0;
      aclr_cnt_r <= 8'h00;
    end
    else if (key_ev)
    begin
      pin_act_r  <= 1'b1;
      rd_lo_r    <= 1'b0;
      rd_hi_r    <= 1'b0;
      aclr_cnt_r <= 8'h00;
    end
    else if (pin_act_r)
    begin
      rd_lo_r <= rd_lo_r | rd_lo;
      rd_hi_r <= rd_hi_r | rd_hi;
      if (ms_tick && (aclr_cnt_r != SAT8))
        aclr_cnt_r <= aclr_cnt_r + ONE8;
      if (both_rd || aclr_exp)
      begin
        pin_act_r  <= 1'b0;
        rd_lo_r    <= 1'b0;
        rd_hi_r    <= 1'b0;
        aclr_cnt_r <= 8'h00;
      end
    end
  end

  assign IRQ_N = ~pin_act_r;

  // Spread spectrum triangle sweep between minus and plus amplitude
  wire [7:0] amp_p = {2'b00, ssc_amp_r};
  wire [7:0] amp_n = 8'h00 - amp_p;
  wire       ssc_on = (ssc_rate_r != 4'h0);
  wire       ssc_step = ssc_on & ((ssc_div_r + ONE4) >= ssc_rate_r);

  always @(posedge REF_CLK)
  begin
    if (RST || !ssc_on)
    begin
      ssc_div_r <= 4'h0;
      ssc_pos_r <= 8'h00;
      ssc_up_r  <= 1'b1;
    end
    else if (ssc_step)
    begin
      ssc_div_r <= 4'h0;
      if (ssc_amp_r == 6'h00)
        ssc_pos_r <= 8'h00;
      else if (ssc_up_r && ($signed(ssc_pos_r) >= $signed(amp_p)))
      begin
        ssc_up_r  <= 1'b0;
        ssc_pos_r <= ssc_pos_r - ONE8;
      end
      else if (!ssc_up_r && ($signed(ssc_pos_r) <= $signed(amp_n)))
      begin
        ssc_up_r  <= 1'b1;
        ssc_pos_r <= ssc_pos_r + ONE8;
      end
      else if (ssc_up_r)
        ssc_pos_r <= ssc_pos_r + ONE8;
      else
        ssc_pos_r <= ssc_pos_r - ONE8;
    end
    else
      ssc_div_r <= ssc_div_r + ONE4;
  end

  assign SSC_ACTIVE = ssc_on;
  assign SSC_OFFSET = ssc_pos_r;

  // Register writes, sticky status with set winning over write-one-clear
  wire [`TKEI_IST_W-1:0] ist_set = {aclr_exp & pin_act_r & ~key_ev, |recal_nxt, key_ev};
  wire ist_wr = wr_en & (idx == `TKEI_IDX_IST);
  wire [`TKEI_IST_W-1:0] ist_clr = ist_wr ? PWDATA[`TKEI_IST_W-1:0] : 3'b000;

  always @(posedge REF_CLK)
  begin
    if (RST)
    begin
      ctrl_r     <= `TKEI_CTRL_RST;
      hold_s_r   <= `TKEI_HOLD_RST;
      aclr_ms_r  <= `TKEI_ACLR_RST;
      ssc_rate_r <= `TKEI_RATE_RST;
      ssc_amp_r  <= `TKEI_AMP_RST;
      first_ms_r <= `TKEI_FIRST_RST;
      rpt_ms_r   <= `TKEI_RPT_RST;
      imsk_r     <= 3'b000;
      ist_r      <= 3'b000;
      prdata_r   <= 32'h00000000;
    end
    else
    begin
      ist_r <= (ist_r & ~ist_clr) | ist_set;
      if (apb_setup && !PWRITE)
        prdata_r <= rd_val;
      if (wr_en)
      begin
        if (idx == `TKEI_IDX_CTRL)
          ctrl_r <= PWDATA[`TKEI_CTRL_W-1:0];
        else if (idx == `TKEI_IDX_HOLD)
          hold_s_r <= PWDATA[7:0];
        else if (idx == `TKEI_IDX_ACLR)
          aclr_ms_r <= PWDATA[7:0];
        else if (idx == `TKEI_IDX_SSC)
        begin
          ssc_rate_r <= PWDATA[`TKEI_SSC_RATE_HI:0];
          ssc_amp_r  <= PWDATA[`TKEI_SSC_AMP_HI:`TKEI_SSC_AMP_LO];
        end
        else if (idx == `TKEI_IDX_RPT)
        begin
          first_ms_r <= PWDATA[15:0];
          rpt_ms_r   <= PWDATA[31:16];
        end
        else if (idx == `TKEI_IDX_IMSK)
          imsk_r <= PWDATA[`TKEI_IST_W-1:0];
      end
    end
  end

  assign IRQ = |(ist_r & imsk_r);
endmodule // tkei_top
`default_nettype wire

// >>> tkei_properties.sv
// Port checker for the key event block
`timescale 1ns/1ns
`default_nettype none
module tkei_chk (
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PSLVERR,
  input wire logic [15:0] KEY_PRESS,
  input wire logic [15:0] KEY_STATE,
  input wire logic [15:0] RECAL_REQ,
  input wire logic        IRQ_N,
  input wire logic        SSC_ACTIVE
);
  reg  [6:0] ctl_r;
  reg  [3:0] rate_r;
  wire       wr  = PSEL & PENABLE & PWRITE;
  wire       rd  = PSEL & PENABLE & !PWRITE & (PADDR == 8'h08 | PADDR == 8'h0C);
  wire       bad = PADDR[1:0] != 2'h0 | PADDR < 8'h08 | PADDR > 8'h28;
  wire [1:0] lc  = (ctl_r[4:3] == 2'h0) ? 2'h1 : ctl_r[4:3];
  // Shadow of control and sweep rate, seen from the bus
  always @(posedge REF_CLK)
  begin
    if (RST)
    begin
      ctl_r <= 7'h40;
      rate_r <= 4'h0;
    end
    else if (wr & PADDR == 8'h10)
      ctl_r <= PWDATA[6:0];
    else if (wr & PADDR == 8'h1C)
      rate_r <= PWDATA[3:0];
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  gie_gate_a: assert property (!ctl_r[6] && !$past(ctl_r[6]) |-> !$fell(IRQ_N))
    else $error("irq with gie off");
  key_irq_a: assert property (ctl_r[6] && $changed(KEY_STATE) |-> !IRQ_N)
    else $error("no irq on key change");
  irq_hold_a: assert property (!IRQ_N && !ctl_r[1] && !rd |=> !IRQ_N)
    else $error("irq released early");
  irq_rel_a: assert property ($rose(IRQ_N) |-> $past(rd) || ctl_r[1])
    else $error("irq released without cause");
  bus_err_a: assert property (PSEL && PENABLE |-> PSLVERR == bad)
    else $error("slave error wrong");
  ssc_on_a: assert property ($stable(rate_r) |-> SSC_ACTIVE == (rate_r != 4'h0))
    else $error("sweep state wrong");
  no_limit_a: assert property (!ctl_r[0] && !ctl_r[2] |=> KEY_STATE == $past(KEY_PRESS))
    else $error("key not reported");
  key_limit_a: assert property (ctl_r[2] && $stable(ctl_r) |=> $countones(KEY_STATE) <= lc)
    else $error("too many keys");
  recal_one_a: assert property (|RECAL_REQ |-> ctl_r[0] ##1 (RECAL_REQ & $past(RECAL_REQ)) == 16'h0000)
    else $error("recal pulse wrong");
endmodule // tkei_chk
bind tkei_top tkei_chk chk_u (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSLVERR(PSLVERR), .KEY_PRESS(KEY_PRESS),
  .KEY_STATE(KEY_STATE), .RECAL_REQ(RECAL_REQ), .IRQ_N(IRQ_N), .SSC_ACTIVE(SSC_ACTIVE));
`default_nettype wire

// >>> tkei_pad.sv
// Sensing side model: touched keys read pressed until recalibrated
`timescale 1ns/1ns
`default_nettype none
module tkei_pad (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] touch,
  input  wire logic [15:0] recal,
  output var  logic [15:0] press
);
  logic [15:0] cal_r;
  // A recalibrated key reads released until the touch goes away
  always @(posedge clk)
    if (rst)
      cal_r <= 16'h0000;
    else
      cal_r <= (cal_r | recal) & touch;
  assign press = touch & ~cal_r;
endmodule // tkei_pad
`default_nettype wire

// >>> tkei_top_tb_top.sv
// Self-checking bench for the key event block
`timescale 1ns/1ns
`default_nettype none
module tkei_top_tb_top;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
  logic [7:0]  pa = 0, soff;
  logic [31:0] pwd = 0, prd, q;
  logic        pready, perr, e, irq_n, irq, ssc_on;
  logic [15:0] touch = 0, press, kst, recal;
  int          err_total = 0, comparisons = 0, cyc = 0, n, l;
  always #2 clk = ~clk;
  tkei_pad pad_u (.clk(clk), .rst(rst), .touch(touch), .recal(recal), .press(press));
  tkei_top #(.MS_CYCLES(10)) dut_u (.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(pready), .PSLVERR(perr),
    .KEY_PRESS(press), .KEY_STATE(kst), .RECAL_REQ(recal), .IRQ_N(irq_n), .IRQ(irq),
    .SSC_ACTIVE(ssc_on), .SSC_OFFSET(soff));
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input [31:0] got, input [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input [7:0] a, input w, input [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input [7:0] a, input [31:0] x);
    bus(a, 1'b0, 32'h0);
    cmp(q, x);
  endtask
  task automatic ack;
    bus(8'h08, 1'b0, 32'h0);
    bus(8'h0C, 1'b0, 32'h0);
  endtask
  task automatic cyc_n(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Cycles until the pin goes low, left in n
  task automatic wait_low(input int lim);
    n = 0;
    while (irq_n !== 1'b0 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_total++;
      wrap_up;
    end
  end
  initial
  begin
    cyc_n(20);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h10, 32'h40);
    rd(8'h18, 32'hC8);
    rd(8'h20, 32'h3E8);
    rd(8'h2C, 32'h0);
    cmp(e, 1'b1);
    touch <= 16'h0001;
    cyc_n(3);
    cmp(irq_n, 1'b0);
    rd(8'h08, 32'h01);
    cmp(irq_n, 1'b0);
    rd(8'h0C, 32'h0);
    cmp(irq_n, 1'b1);
    touch <= 16'h0;
    wait_low(20);
    cmp(irq_n, 1'b0);
    ack;
    cyc_n(100);
    cmp(irq_n, 1'b1);
    bus(8'h18, 1'b1, 32'h0A);
    bus(8'h10, 1'b1, 32'h42);
    bus(8'h24, 1'b1, 32'h7);
    bus(8'h28, 1'b1, 32'h4);
    touch <= 16'h0002;
    cyc_n(80);
    cmp(irq_n, 1'b0);
    cmp(irq, 1'b0);
    cyc_n(30);
    cmp(irq_n, 1'b1);
    cmp(irq, 1'b1);
    rd(8'h24, 32'h5);
    bus(8'h24, 1'b1, 32'h4);
    rd(8'h24, 32'h1);
    cmp(irq, 1'b0);
    touch <= 16'h0;
    cyc_n(3);
    ack;
    bus(8'h20, 1'b1, 32'h0003_0005);
    bus(8'h10, 1'b1, 32'h60);
    touch <= 16'h0004;
    wait_low(10);
    ack;
    wait_low(100);
    cmp(n > 25 && n < 48, 1'b1);
    ack;
    wait_low(100);
    cmp(n > 10 && n < 28, 1'b1);
    ack;
    touch <= 16'h0;
    wait_low(10);
    cmp(n < 5, 1'b1);
    ack;
    cyc_n(60);
    cmp(irq_n, 1'b1);
    bus(8'h10, 1'b1, 32'h00);
    touch <= 16'h0008;
    cyc_n(5);
    cmp(irq_n, 1'b1);
    cmp(kst, 16'h0008);
    touch <= 16'h0;
    cyc_n(3);
    for (l = 1; l < 4; l++)
    begin
      bus(8'h10, 1'b1, 32'h44 | (l << 3));
      touch <= 16'h00F0;
      cyc_n(3);
      cmp(kst, (16'h0010 << l) - 16'h0010);
      touch <= 16'h0;
      cyc_n(3);
      ack;
    end
    bus(8'h14, 1'b1, 32'h1);
    bus(8'h10, 1'b1, 32'h41);
    touch <= 16'h0020;
    n = 0;
    while (recal[5] !== 1'b1 && n < 25000)
    begin
      @(posedge clk);
      n++;
    end
    cmp(recal[5], 1'b1);
    cyc_n(3);
    cmp(kst[5], 1'b0);
    touch <= 16'h0;
    ack;
    bus(8'h1C, 1'b1, 32'h0203);
    cyc_n(2);
    cmp(ssc_on, 1'b1);
    l = 0;
    repeat (40)
    begin
      @(posedge clk);
      cmp($signed(soff) <= 2 && $signed(soff) >= -2, 1'b1);
      if ($signed(soff) == 2)
        l = 1;
    end
    cmp(l, 1);
    bus(8'h1C, 1'b1, 32'h0);
    cyc_n(2);
    cmp(ssc_on, 1'b0);
    rst <= 1'b1;
    cyc_n(3);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h10, 32'h40);
    cmp(irq_n, 1'b1);
    wrap_up;
  end
endmodule // tkei_top_tb_top
`default_nettype wire
